// ### logic/lcg4_top.sv
// Purpose: gate-four input select register, gate-four OR, and cell output mirror
// Assumes: data lines and cell outputs come from logic on the same clock
// Notes: ack answers one cycle after request, drops the cycle after
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
module lcg4_top
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [3:0] i_data,
	input wire logic [2:0] i_cell_out,
	output logic o_gate_four
);
	lcg4_pkg::lcg4_wb_req_s req;
	logic [7:0] gate_four_input_select;
	logic [7:0] next_gate_four_input_select;
	logic [7:0] logic_cell_output_mirror;
	logic [7:0] forms;
	logic ack;
	logic next_ack;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	logic gate;
	logic next_gate;
	logic hit;

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, adr: i_wb_adr, sel: i_wb_sel, dat: i_wb_dat};
	assign hit = req.cyc && req.stb && !ack;

	// pair each data line as {true, inverted} matching select bit order
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_forms
			assign forms[2*g+1] = i_data[g]; // [R1] [R3] [R4] [R5]
			assign forms[2*g] = ~i_data[g]; // [R2] [R3] [R4] [R5]
		end
	endgenerate

	// bits above the three cell copies are constant zero
	assign logic_cell_output_mirror = {5'h00, i_cell_out}; // [R7] [R8]

	always_comb
	begin
		next_gate_four_input_select = gate_four_input_select;
		next_ack = hit;
		next_rdat = rdat;
		next_gate = |(forms & gate_four_input_select); // [R9]
		if (hit)
		begin
			if (req.we && req.adr == lcg4_pkg::lcg4_off_select && req.sel[0])
			begin
				next_gate_four_input_select = req.dat[7:0]; // [R6]
			end
			if (!req.we)
			begin
				unique case (req.adr)
					lcg4_pkg::lcg4_off_select: next_rdat = {24'h000000, gate_four_input_select}; // [R6]
					lcg4_pkg::lcg4_off_mirror: next_rdat = {24'h000000, logic_cell_output_mirror}; // [R7] [R8]
					default: next_rdat = lcg4_pkg::lcg4_unmapped_read;
				endcase
			end
		end
	end

	// select register has no reset: it keeps its value across every reset
	always_ff @(posedge i_clk)
	begin
		gate_four_input_select <= next_gate_four_input_select; // [R6]
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ack <= 1'b0;
			rdat <= 32'h00000000;
			gate <= 1'b0;
		end
		else
		begin
			ack <= next_ack;
			rdat <= next_rdat;
			gate <= next_gate;
		end
	end

	assign o_wb_ack = ack;
	assign o_wb_dat = rdat;
	assign o_gate_four = gate;
endmodule : lcg4_top

// ### logic/lcg4_pkg.sv
// Purpose: constants and carriers for the gate-four select and cell output mirror block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: register offsets are local choices
// How it works
// (R1) select bit 7 set feeds true data line four into gate four
// (R2) select bit 6 set feeds inverted data line four into gate four
// (R3) bits 5 and 4 feed true and inverted data line three
// (R4) bits 3 and 2 feed true and inverted data line two
// (R5) bits 1 and 0 feed true and inverted data line one
// (R6) select register is read/write, untouched by reset, unknown at power-on
// (R7) mirror register bits 2..0 show live outputs of cells three, two, one
// (R8) mirror bits 7..3 read zero and ignore writes
// (R9) gate four is OR of selected forms, zero when nothing selected
package lcg4_pkg;
	localparam logic [3:0] lcg4_off_select = 4'h0;
	localparam logic [3:0] lcg4_off_mirror = 4'h4;
	localparam int lcg4_sel_width = 8;
	localparam int lcg4_cells = 3;
	localparam logic [7:0] lcg4_mirror_reset = 8'h00;
	localparam logic [31:0] lcg4_unmapped_read = 32'h00000000;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} lcg4_wb_req_s;
endpackage : lcg4_pkg

// ### verif/lcg4_monitor.sv
// Purpose: lcg4_top port checks; Assumes: one clock; Notes: s shadows the select register
`timescale 1ns/10ps
module lcg4_monitor
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_data,
	input wire logic [2:0] i_cell_out,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_gate_four
);
	wire logic t = i_wb_cyc && i_wb_stb && !o_wb_ack;
	logic [7:0] s;
	logic v;
	wire logic g = |(s & {i_data[3], ~i_data[3], i_data[2], ~i_data[2], i_data[1], ~i_data[1], i_data[0], ~i_data[0]});
	always_ff @(posedge i_clk) if (t && i_wb_we && i_wb_adr == 4'h0 && i_wb_sel[0]) {v, s} <= {1'b1, i_wb_dat[7:0]};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	ack_next_a: assert property (t |=> o_wb_ack) else $error("ack late");
	ack_once_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
	mirror_read_a: assert property (t && !i_wb_we && i_wb_adr == 4'h4 |=> o_wb_dat == {29'h0, $past(i_cell_out)}) else $error("mirror");
	select_read_a: assert property (v && t && !i_wb_we && i_wb_adr == 4'h0 |=> o_wb_dat == {24'h0, $past(s)}) else $error("select");
	gate_or_a: assert property (v && i_arst_n |=> o_gate_four == $past(g)) else $error("gate");
	read_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper bits");
endmodule : lcg4_monitor
bind lcg4_top lcg4_monitor mon (.*);

// ### verif/lcg4_top_bench.sv
// Purpose: lcg4_top register and gate tests; Assumes: ack pulse; Notes: none
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %0t %h %h", $time, a, e); end end
module lcg4_top_bench;
	logic i_clk = 0, i_arst_n = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, o_wb_ack, o_gate_four;
	logic [3:0] i_wb_adr = '0, i_wb_sel = '0, i_data = '0;
	logic [2:0] i_cell_out = '0;
	logic [31:0] i_wb_dat = '0, o_wb_dat, r;
	int error_cnt = 0, checks = 0, n = 0;
	lcg4_top dut (.*);
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) if (++n > 3000) begin error_cnt++; end_sim(); end
	task end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge i_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} <= {2'b11, w, a, s, d};
		do @(posedge i_clk); while (o_wb_ack !== 1'b1);
		r = o_wb_dat;
		{i_wb_cyc, i_wb_stb} <= 2'b00;
	endtask : wb
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1;
		for (int i = 0; i < 8; i++)
		begin
			wb(1, 4'h0, 4'h1, 32'h1 << i); wb(0, 4'h0, 4'h1, 0); `CHK(r, 32'h1 << i)
			for (int d = 0; d < 2; d++)
			begin
				i_data <= {4{d[0]}}; repeat (3) @(posedge i_clk); `CHK(o_gate_four, i[0] ? d[0] : ~d[0])
			end
		end
		wb(1, 4'h0, 4'h0, 32'hff); wb(0, 4'h0, 4'h1, 0); `CHK(r, 32'h80)
		i_cell_out <= 3'h5; wb(1, 4'h4, 4'h1, 32'hff); wb(0, 4'h4, 4'h1, 0); `CHK(r, 32'h5)
		wb(0, 4'h8, 4'h1, 0); `CHK(r, 32'h0)
		@(posedge i_clk); i_arst_n <= 0; @(posedge i_clk); i_arst_n <= 1;
		wb(0, 4'h0, 4'h1, 0); `CHK(r, 32'h80)
		wb(1, 4'h0, 4'h1, 0); repeat (3) @(posedge i_clk); `CHK(o_gate_four, 1'b0)
		end_sim();
	end
endmodule : lcg4_top_bench
